/* upv_pkg.sv */
// Constants, codes and register map of the printer port vendor access block
package upv_pkg;
  // Vendor request framing
  localparam logic [7:0]  REQ_TYPE_READ  = 8'hc0;
  localparam logic [7:0]  REQ_TYPE_WRITE = 8'h40;
  localparam logic [7:0]  REQ_CODE_READ  = 8'h0d;
  localparam logic [7:0]  REQ_CODE_WRITE = 8'h0e;
  localparam logic [15:0] LEN_READ       = 16'h0001;
  localparam logic [15:0] LEN_WRITE      = 16'h0000;
  // Application numbers (value field high byte)
  localparam logic [7:0]  APP_AUX        = 8'h00;
  localparam logic [7:0]  APP_PRINTER    = 8'h01;
  localparam logic [7:0]  APP_RESERVED   = 8'h02;
  // Register offsets (index field)
  localparam logic [15:0] OFS_DATA       = 16'h0000;
  localparam logic [15:0] OFS_STATUS     = 16'h0001;
  localparam logic [15:0] OFS_CONTROL    = 16'h0002;
  localparam logic [15:0] OFS_FIFO_CONFA = 16'h0008;
  localparam logic [15:0] OFS_CONFIG_B   = 16'h0009;
  localparam logic [15:0] OFS_MODE       = 16'h000a;
  localparam logic [15:0] OFS_AUX        = 16'h0004;
  // Reset values
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  CONFIG_RESET   = 8'h00;
  localparam logic [7:0]  MODE_RESET     = 8'h20;
  localparam logic [7:0]  AUX_RESET      = 8'h00;
  // Control register fields
  localparam int          CTL_STROBE     = 0;
  localparam int          CTL_AUTOFD     = 1;
  localparam int          CTL_INIT       = 2;
  localparam int          CTL_SELECTIN   = 3;
  localparam int          CTL_DIR        = 5;
  localparam logic [7:0]  CTL_WR_MASK    = 8'h2f;
  // Mode field in bits 7..5 of the mode select register
  localparam int          MODE_HI        = 7;
  localparam int          MODE_LO        = 5;
  localparam logic [2:0]  MODE_SPP       = 3'h0;
  localparam logic [2:0]  MODE_NIBBLE    = 3'h1;
  localparam logic [2:0]  MODE_FIFO      = 3'h2;
  // Status report layout
  localparam logic [7:0]  REPORT_RSVD    = 8'h00;
  localparam logic [1:0]  REPORT_LAST    = 2'h3;
  // Descriptor table: interface (9) plus three endpoints (7 each)
  localparam int          DESC_BYTES     = 30;
  localparam logic [4:0]  DESC_LAST      = 5'h1d;
  // Report period
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          REPORT_TIME_US = 1000;
  localparam int          REPORT_CYCLES  = (REPORT_TIME_US * 1000000) / CLK_PERIOD_PS;
  typedef enum logic [0:0] {UPV_REP_IDLE, UPV_REP_SEND} upv_rep_state_t;
endpackage

/* upv_buf2.sv */
// Two-entry valid/ready buffer for the status report byte stream
`timescale 1ns/100ps
`default_nettype none
module upv_buf2 import upv_pkg::*; #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot_reg [2];
  logic [WIDTH-1:0] slot_next [2];
  logic             wptr_reg, wptr_next;
  logic             rptr_reg, rptr_next;
  logic [1:0]       count_reg, count_next;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot_reg[rptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and slot updates
  always_comb begin
    slot_next  = slot_reg;
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    count_next = count_reg;
    if (push) begin
      slot_next[wptr_reg] = in_data;
      wptr_next           = ~wptr_reg;
    end
    if (pop) begin
      rptr_next = ~rptr_reg;
    end
    count_next = count_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
      wptr_reg    <= 1'b0;
      rptr_reg    <= 1'b0;
      count_reg   <= 2'h0;
    end else begin
      slot_reg  <= slot_next;
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      count_reg <= count_next;
    end
  end

  a_buf_no_over : assert property (@(posedge clock) disable iff (!nrst) count_reg <= 2'h2)
    else $error("buffer count above two");
endmodule // upv_buf2
`default_nettype wire

/* upv_port_access.sv */
// Vendor register access, descriptors and status report of the printer port function
`timescale 1ns/100ps
`default_nettype none
module upv_port_access import upv_pkg::*; #(
  parameter int REPORT_PERIOD = REPORT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  // Setup stage of a control transfer on endpoint zero
  input  wire logic        setup_valid,
  input  wire logic [7:0]  setup_req_type,
  input  wire logic [7:0]  setup_request,
  input  wire logic [15:0] setup_value,
  input  wire logic [15:0] setup_index,
  input  wire logic [15:0] setup_length,
  output logic             ctl_done,
  output logic             ctl_stall,
  output logic             ctl_rd_valid,
  output logic [7:0]       ctl_rd_data,
  // Descriptor table read port
  input  wire logic [4:0]  desc_addr,
  output logic [7:0]       desc_data,
  // Status endpoint byte stream
  output logic             ep_status_valid,
  input  wire logic        ep_status_ready,
  output logic [7:0]       ep_status_data,
  // FIFO flags and FIFO port
  input  wire logic        in_fifo_full_flag,
  input  wire logic        in_fifo_empty_flag,
  input  wire logic        out_fifo_full_flag,
  input  wire logic        out_fifo_empty_flag,
  output logic             fifo_wr_valid,
  output logic [7:0]       fifo_wr_data,
  output logic             fifo_rd_take,
  input  wire logic [7:0]  fifo_rd_data,
  // Printer port pins
  input  wire logic [7:0]  printer_data_pins_in,
  output logic [7:0]       printer_data_pins_out,
  output logic             printer_data_pins_oe,
  input  wire logic        busy_pin_n,
  input  wire logic        ack_pin_n,
  input  wire logic        paper_end_pin,
  input  wire logic        online_pin,
  input  wire logic        fault_pin_n,
  output logic             strobe_pin_n,
  output logic             autofd_pin_n,
  output logic             init_pin_n,
  output logic             select_in_pin_n,
  // Register contents used elsewhere in the port
  output logic [7:0]       port_config_a,
  output logic [7:0]       port_config_b,
  output logic [7:0]       port_mode_select,
  output logic [7:0]       aux_control
);
  // Register file
  logic [7:0]  printer_data_reg, printer_data_next;
  logic [7:0]  printer_control_reg, printer_control_next;
  logic [7:0]  config_a_reg, config_a_next;
  logic [7:0]  config_b_reg, config_b_next;
  logic [7:0]  mode_reg, mode_next;
  logic [7:0]  aux_reg, aux_next;
  // Answer to the host
  logic        done_reg, done_next;
  logic        stall_reg, stall_next;
  logic        rd_valid_reg, rd_valid_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  logic        fifo_wr_reg, fifo_wr_next;
  logic [7:0]  fifo_wdata_reg, fifo_wdata_next;
  logic        fifo_take_reg, fifo_take_next;
  // Decode
  logic        is_read, is_write;
  logic [7:0]  app;
  logic [7:0]  wbyte;
  logic        ofs_ok;
  logic        fifo_mode;
  logic        dir_in;
  logic [7:0]  printer_status;
  logic [7:0]  fifo_flags;

  // Status byte built from the pins; unused low bits read zero
  assign printer_status = {~busy_pin_n, ~ack_pin_n, paper_end_pin, online_pin, fault_pin_n, 3'h0};
  assign fifo_flags     = {4'h0, out_fifo_empty_flag, out_fifo_full_flag,
                           in_fifo_empty_flag, in_fifo_full_flag};

  // SPP mode is forward only, so the direction bit is ignored there
  assign fifo_mode = (mode_reg[MODE_HI:MODE_LO] == MODE_FIFO);
  assign dir_in    = printer_control_reg[CTL_DIR] & (mode_reg[MODE_HI:MODE_LO] != MODE_SPP);

  // Request framing and application select
  assign is_read  = (setup_req_type == REQ_TYPE_READ) && (setup_request == REQ_CODE_READ)
                    && (setup_length == LEN_READ);
  assign is_write = (setup_req_type == REQ_TYPE_WRITE) && (setup_request == REQ_CODE_WRITE)
                    && (setup_length == LEN_WRITE);
  assign app      = setup_value[15:8];
  assign wbyte    = setup_value[7:0];

  // Known offsets per application; the reserved application has none
  always_comb begin
    ofs_ok = 1'b0;
    if (app == APP_PRINTER) begin
      case (setup_index)
        OFS_DATA, OFS_STATUS, OFS_CONTROL, OFS_FIFO_CONFA, OFS_CONFIG_B, OFS_MODE: ofs_ok = 1'b1;
        default: ofs_ok = 1'b0;
      endcase
    end else if (app == APP_AUX) begin
      ofs_ok = (setup_index == OFS_AUX);
    end
  end

  // Register reads, writes and the answer; one request is finished in one cycle
  always_comb begin
    printer_data_next    = printer_data_reg;
    printer_control_next = printer_control_reg;
    config_a_next        = config_a_reg;
    config_b_next        = config_b_reg;
    mode_next            = mode_reg;
    aux_next             = aux_reg;
    done_next            = 1'b0;
    stall_next           = 1'b0;
    rd_valid_next        = 1'b0;
    rd_data_next         = rd_data_reg;
    fifo_wr_next         = 1'b0;
    fifo_wdata_next      = fifo_wdata_reg;
    fifo_take_next       = 1'b0;
    if (setup_valid) begin
      if (!((is_read || is_write) && ofs_ok)) begin
        stall_next = 1'b1;
      end else if (is_read) begin
        done_next     = 1'b1;
        rd_valid_next = 1'b1;
        if (app == APP_AUX) begin
          rd_data_next = aux_reg;
        end else begin
          case (setup_index)
            OFS_DATA:    rd_data_next = printer_data_pins_in;
            OFS_STATUS:  rd_data_next = printer_status;
            OFS_CONTROL: rd_data_next = printer_control_reg;
            OFS_FIFO_CONFA: begin
              // Offset 8 is the FIFO port in FIFO mode, configuration A otherwise
              rd_data_next   = fifo_mode ? fifo_rd_data : config_a_reg;
              fifo_take_next = fifo_mode;
            end
            OFS_CONFIG_B: rd_data_next = config_b_reg;
            default:      rd_data_next = mode_reg;
          endcase
        end
      end else begin
        done_next = 1'b1;
        if (app == APP_AUX) begin
          aux_next = wbyte;
        end else begin
          case (setup_index)
            OFS_DATA:    printer_data_next = wbyte;
            OFS_STATUS:  printer_data_next = printer_data_reg; // Status follows the pins only
            OFS_CONTROL: printer_control_next = wbyte & CTL_WR_MASK;
            OFS_FIFO_CONFA: begin
              if (fifo_mode) begin
                fifo_wr_next    = 1'b1;
                fifo_wdata_next = wbyte;
              end else begin
                config_a_next = wbyte;
              end
            end
            OFS_CONFIG_B: config_b_next = wbyte;
            default:      mode_next = wbyte;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      printer_data_reg    <= DATA_RESET;
      printer_control_reg <= CONTROL_RESET;
      config_a_reg        <= CONFIG_RESET;
      config_b_reg        <= CONFIG_RESET;
      mode_reg            <= MODE_RESET;
      aux_reg             <= AUX_RESET;
      done_reg            <= 1'b0;
      stall_reg           <= 1'b0;
      rd_valid_reg        <= 1'b0;
      rd_data_reg         <= 8'h00;
      fifo_wr_reg         <= 1'b0;
      fifo_wdata_reg      <= 8'h00;
      fifo_take_reg       <= 1'b0;
    end else begin
      printer_data_reg    <= printer_data_next;
      printer_control_reg <= printer_control_next;
      config_a_reg        <= config_a_next;
      config_b_reg        <= config_b_next;
      mode_reg            <= mode_next;
      aux_reg             <= aux_next;
      done_reg            <= done_next;
      stall_reg           <= stall_next;
      rd_valid_reg        <= rd_valid_next;
      rd_data_reg         <= rd_data_next;
      fifo_wr_reg         <= fifo_wr_next;
      fifo_wdata_reg      <= fifo_wdata_next;
      fifo_take_reg       <= fifo_take_next;
    end
  end

  // Pins: control bits at 1 pull the matching pin low
  assign printer_data_pins_out = printer_data_reg;
  assign printer_data_pins_oe  = ~dir_in;
  assign strobe_pin_n          = ~printer_control_reg[CTL_STROBE];
  assign autofd_pin_n          = ~printer_control_reg[CTL_AUTOFD];
  assign init_pin_n            = ~printer_control_reg[CTL_INIT];
  assign select_in_pin_n       = ~printer_control_reg[CTL_SELECTIN];
  assign ctl_done              = done_reg;
  assign ctl_stall             = stall_reg;
  assign ctl_rd_valid          = rd_valid_reg;
  assign ctl_rd_data           = rd_data_reg;
  assign fifo_wr_valid         = fifo_wr_reg;
  assign fifo_wr_data          = fifo_wdata_reg;
  assign fifo_rd_take          = fifo_take_reg;
  assign port_config_a         = config_a_reg;
  assign port_config_b         = config_b_reg;
  assign port_mode_select      = mode_reg;
  assign aux_control           = aux_reg;

  // Descriptor table: interface, bulk in, bulk out, status endpoint; first byte in the top lane
  localparam logic [71:0]  DESC_IFACE    = 72'h09_04_00_00_03_ff_00_ff_00;
  localparam logic [55:0]  DESC_BULK_IN  = 56'h07_05_81_02_20_00_ff;
  localparam logic [55:0]  DESC_BULK_OUT = 56'h07_05_02_02_20_00_ff;
  localparam logic [55:0]  DESC_STATUS   = 56'h07_05_87_03_04_00_01;
  localparam logic [239:0] DESC_TABLE    = {DESC_IFACE, DESC_BULK_IN, DESC_BULK_OUT, DESC_STATUS};
  logic [7:0] desc_data_reg, desc_data_next;
  // Addresses past the table read zero rather than wrapping into it
  always_comb begin
    desc_data_next = 8'h00;
    if (desc_addr <= DESC_LAST) begin
      desc_data_next = DESC_TABLE[{DESC_LAST - desc_addr, 3'h0} +: 8];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      desc_data_reg <= 8'h00;
    end else begin
      desc_data_reg <= desc_data_next;
    end
  end
  assign desc_data = desc_data_reg;

  // Status report: snapshot once a period, then four bytes into the buffer
  upv_rep_state_t rep_state_reg, rep_state_next;
  logic [31:0]    tick_reg, tick_next;
  logic [1:0]     byte_reg, byte_next;
  logic [7:0]     snap_status_reg, snap_status_next;
  logic [7:0]     snap_flags_reg, snap_flags_next;
  logic           buf_in_valid, buf_in_ready;
  logic [7:0]     buf_in_data;
  logic           period_end;

  assign period_end = (tick_reg == 32'(REPORT_PERIOD - 1));

  always_comb begin
    case (byte_reg)
      2'h2:    buf_in_data = snap_status_reg;
      2'h3:    buf_in_data = snap_flags_reg;
      default: buf_in_data = REPORT_RSVD;
    endcase
  end
  assign buf_in_valid = (rep_state_reg == UPV_REP_SEND);

  // Period keeps running even if the host stalls; a late report is not restarted
  always_comb begin
    rep_state_next   = rep_state_reg;
    tick_next        = period_end ? 32'h0 : tick_reg + 32'h1;
    byte_next        = byte_reg;
    snap_status_next = snap_status_reg;
    snap_flags_next  = snap_flags_reg;
    case (rep_state_reg)
      UPV_REP_IDLE: begin
        if (period_end) begin
          rep_state_next   = UPV_REP_SEND;
          byte_next        = 2'h0;
          snap_status_next = printer_status;
          snap_flags_next  = fifo_flags;
        end
      end
      UPV_REP_SEND: begin
        if (buf_in_ready) begin
          byte_next = byte_reg + 2'h1;
          if (byte_reg == REPORT_LAST) begin
            rep_state_next = UPV_REP_IDLE;
          end
        end
      end
      default: rep_state_next = UPV_REP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rep_state_reg   <= UPV_REP_IDLE;
      tick_reg        <= 32'h0;
      byte_reg        <= 2'h0;
      snap_status_reg <= 8'h00;
      snap_flags_reg  <= 8'h00;
    end else begin
      rep_state_reg   <= rep_state_next;
      tick_reg        <= tick_next;
      byte_reg        <= byte_next;
      snap_status_reg <= snap_status_next;
      snap_flags_reg  <= snap_flags_next;
    end
  end

  upv_buf2 #(.WIDTH(8)) u_report_buf (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (ep_status_valid),
    .out_ready (ep_status_ready),
    .out_data  (ep_status_data)
  );

  // Checks on the behaviour above
  a_read_answer : assert property (@(posedge clock) disable iff (!nrst)
    setup_valid && is_read && ofs_ok |=> ctl_rd_valid && ctl_done && !ctl_stall)
    else $error("valid read not answered");
  a_write_nodata : assert property (@(posedge clock) disable iff (!nrst)
    setup_valid && is_write |=> !ctl_rd_valid)
    else $error("write produced read data");
  a_bad_stall : assert property (@(posedge clock) disable iff (!nrst)
    setup_valid && (app == APP_RESERVED) |=> ctl_stall && !ctl_done && $stable(printer_data_reg))
    else $error("reserved application not stalled");
  a_data_write : assert property (@(posedge clock) disable iff (!nrst)
    setup_valid && is_write && app == APP_PRINTER && setup_index == OFS_DATA
    |=> printer_data_pins_out == $past(setup_value[7:0]))
    else $error("data write not on pins");
  a_data_read : assert property (@(posedge clock) disable iff (!nrst)
    setup_valid && is_read && app == APP_PRINTER && setup_index == OFS_DATA
    |=> ctl_rd_data == $past(printer_data_pins_in))
    else $error("data read not from pins");
  a_status_read : assert property (@(posedge clock) disable iff (!nrst)
    setup_valid && is_read && app == APP_PRINTER && setup_index == OFS_STATUS
    |=> ctl_rd_data[2:0] == 3'h0 && ctl_rd_data[7] == !$past(busy_pin_n))
    else $error("status byte layout wrong");
  a_dir_pins : assert property (@(posedge clock) disable iff (!nrst)
    (mode_reg[MODE_HI:MODE_LO] != MODE_SPP) |-> printer_data_pins_oe == !printer_control_reg[CTL_DIR])
    else $error("pin direction does not follow control");
  a_reset_data : assert property (@(posedge clock)
    $rose(nrst) |-> printer_data_pins_out == DATA_RESET)
    else $error("data register not cleared by reset");
  a_report_start : assert property (@(posedge clock) disable iff (!nrst)
    period_end && rep_state_reg == UPV_REP_IDLE |=> buf_in_valid && byte_reg == 2'h0)
    else $error("report not started at period end");
  a_report_bytes : assert property (@(posedge clock) disable iff (!nrst)
    buf_in_valid && byte_reg == REPORT_LAST |-> buf_in_data[7:4] == 4'h0 && buf_in_data == snap_flags_reg)
    else $error("flag byte wrong");
  a_desc_iface : assert property (@(posedge clock) disable iff (!nrst)
    desc_addr == 5'h04 |=> desc_data == 8'h03)
    else $error("endpoint count wrong");

  c_read  : cover property (@(posedge clock) disable iff (!nrst) setup_valid && is_read && ofs_ok);
  c_write : cover property (@(posedge clock) disable iff (!nrst) setup_valid && is_write && ofs_ok);
  c_stall : cover property (@(posedge clock) disable iff (!nrst) ctl_stall);
  c_held  : cover property (@(posedge clock) disable iff (!nrst) buf_in_valid && !buf_in_ready);
endmodule // upv_port_access
`default_nettype wire

/* upv_host_model.sv */
// Host model that drains the status endpoint stream and rebuilds reports
`timescale 1ns/100ps
`default_nettype none
module upv_host_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       slow,
  input  wire logic       ep_status_valid,
  output logic            ep_status_ready,
  input  wire logic [7:0] ep_status_data,
  output logic [31:0]     report,
  output var int          n_reports
);
  logic [23:0] part_reg;
  logic [1:0]  cnt_reg;
  logic        tog_reg;
  // A slow host takes a byte only every other cycle, so the buffer must hold
  assign ep_status_ready = !slow || tog_reg;
  // Four taken bytes make one report, first byte in the top lane
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {part_reg, cnt_reg, tog_reg, report} <= '0;
      n_reports <= 0;
    end else begin
      tog_reg <= !tog_reg;
      if (ep_status_valid && ep_status_ready) begin
        cnt_reg <= cnt_reg + 2'h1;
        part_reg <= {part_reg[15:0], ep_status_data};
        if (cnt_reg == 2'h3) begin
          report <= {part_reg, ep_status_data};
          n_reports <= n_reports + 1;
        end
      end
    end
  end
endmodule // upv_host_model
`default_nettype wire

/* upv_port_access_tb_top.sv */
// Self-checking bench for the printer port vendor access block
`timescale 1ns/100ps
`default_nettype none
module upv_port_access_tb_top import upv_pkg::*;;
  typedef struct packed {logic rd; logic [15:0] val; logic [15:0] idx; logic stall; logic [7:0] exp;} upv_row_t;
  localparam logic [239:0] DESC = 240'h0904000003ff00ff00_070581022000ff_070502022000ff_07058703040001;
  logic        clock, nrst, setup_valid, ctl_done, ctl_stall, ctl_rd_valid, printer_data_pins_oe, slow;
  logic        ep_status_valid, ep_status_ready;
  logic [7:0]  setup_req_type, setup_request, ctl_rd_data, desc_data, ep_status_data, printer_data_pins_out;
  logic [15:0] setup_value, setup_index, setup_length;
  logic [4:0]  desc_addr, pin_lv;
  logic [3:0]  flags, ctl_pins_n;
  logic [31:0] report;
  logic        fifo_wr_valid, fifo_rd_take;
  logic [7:0]  fifo_wr_data, port_config_a;
  int          n_reports, failures, n_tests, cycles, n0;
  // Printer drives 3c whenever the port has turned its data pins to input
  wire logic [7:0] pins_in = printer_data_pins_oe ? printer_data_pins_out : 8'h3c;
  upv_row_t rows [14] = '{'{0, 16'h01a5, 16'h0, 0, 8'h0}, '{1, 16'h0100, 16'h0, 0, 8'ha5},
    '{0, 16'h0120, 16'h2, 0, 8'h0}, '{1, 16'h0100, 16'h0, 0, 8'h3c}, '{1, 16'h0100, 16'h2, 0, 8'h20},
    '{1, 16'h0100, 16'h1, 0, 8'ha8}, '{0, 16'h015a, 16'h9, 0, 8'h0}, '{0, 16'h0111, 16'h3, 1, 8'h0},
    '{0, 16'h0233, 16'h9, 1, 8'h0}, '{1, 16'h0100, 16'h9, 0, 8'h5a}, '{0, 16'h0066, 16'h4, 0, 8'h0},
    '{1, 16'h0000, 16'h4, 0, 8'h66}, '{1, 16'h0100, 16'h4, 1, 8'h0}, '{0, 16'h0100, 16'ha, 0, 8'h0}};
  upv_port_access #(.REPORT_PERIOD(40)) u_upv_port_access (.clock, .nrst, .setup_valid, .setup_req_type,
    .setup_request, .setup_value, .setup_index, .setup_length, .ctl_done, .ctl_stall, .ctl_rd_valid,
    .ctl_rd_data, .desc_addr, .desc_data, .ep_status_valid, .ep_status_ready, .ep_status_data,
    .in_fifo_full_flag(flags[0]), .in_fifo_empty_flag(flags[1]), .out_fifo_full_flag(flags[2]),
    .out_fifo_empty_flag(flags[3]), .fifo_wr_valid, .fifo_wr_data, .fifo_rd_take, .fifo_rd_data(8'h96),
    .printer_data_pins_in(pins_in), .printer_data_pins_out, .printer_data_pins_oe, .busy_pin_n(pin_lv[4]),
    .ack_pin_n(pin_lv[3]), .paper_end_pin(pin_lv[2]), .online_pin(pin_lv[1]), .fault_pin_n(pin_lv[0]),
    .strobe_pin_n(ctl_pins_n[0]), .autofd_pin_n(ctl_pins_n[1]), .init_pin_n(ctl_pins_n[2]),
    .select_in_pin_n(ctl_pins_n[3]), .port_config_a,
    .port_config_b(), .port_mode_select(), .aux_control());
  upv_host_model u_upv_host_model (.clock, .nrst, .slow, .ep_status_valid, .ep_status_ready,
    .ep_status_data, .report, .n_reports);
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One idle cycle, then one setup cycle; the answer is settled at the closing falling edge
  task automatic req(logic [7:0] t, logic [7:0] c, logic [15:0] v, logic [15:0] i, logic [15:0] l);
    @(negedge clock);
    {setup_req_type, setup_request, setup_value, setup_index, setup_length, setup_valid} = {t, c, v, i, l, 1'b1};
    @(negedge clock);
    setup_valid = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end
  // Run is about 350 cycles; the ceiling leaves a wide margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    {nrst, setup_valid, setup_req_type, setup_request, setup_value, setup_index, setup_length, desc_addr, slow} = '0;
    flags = 4'b1001;
    pin_lv = 5'b01101;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    foreach (rows[k]) begin
      req(rows[k].rd ? REQ_TYPE_READ : REQ_TYPE_WRITE, rows[k].rd ? REQ_CODE_READ : REQ_CODE_WRITE,
          rows[k].val, rows[k].idx, rows[k].rd ? LEN_READ : LEN_WRITE);
      chk("answer", {5'h0, ctl_stall, ctl_done, ctl_rd_valid}, {5'h0, rows[k].stall, !rows[k].stall,
          rows[k].rd && !rows[k].stall});
      if (rows[k].rd && !rows[k].stall) chk("read byte", ctl_rd_data, rows[k].exp);
    end
    // Wrong lengths are refused; SPP mode turns the pins back to output
    req(REQ_TYPE_READ, REQ_CODE_READ, 16'h0100, OFS_DATA, 16'h0002);
    chk("bad read length", {7'h0, ctl_stall}, 8'h01);
    req(REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h01ff, OFS_DATA, 16'h0001);
    chk("bad write length", {7'h0, ctl_stall}, 8'h01);
    req(REQ_TYPE_READ, REQ_CODE_READ, 16'h0100, OFS_DATA, LEN_READ);
    chk("data kept", ctl_rd_data, 8'ha5);
    // SPP keeps the pins driven with the direction bit set; control bits pull their pins low
    req(REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h01ff, OFS_CONTROL, LEN_WRITE);
    chk("oe and control pins", {3'h0, printer_data_pins_oe, ctl_pins_n}, 8'h10);
    req(REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0177, OFS_FIFO_CONFA, LEN_WRITE);
    chk("config a", port_config_a, 8'h77);
    // FIFO mode turns offset 8 into the FIFO port
    req(REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0140, OFS_MODE, LEN_WRITE);
    req(REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h01c3, OFS_FIFO_CONFA, LEN_WRITE);
    chk("fifo write strobe", {7'h0, fifo_wr_valid}, 8'h01);
    chk("fifo write data", fifo_wr_data, 8'hc3);
    req(REQ_TYPE_READ, REQ_CODE_READ, 16'h0100, OFS_FIFO_CONFA, LEN_READ);
    chk("fifo read", ctl_rd_data, 8'h96);
    chk("fifo take", {7'h0, fifo_rd_take}, 8'h01);
    chk("config a kept", port_config_a, 8'h77);
    for (int a = 0; a < 31; a++) begin
      desc_addr = a[4:0];
      @(negedge clock);
      chk("descriptor", desc_data, a < 30 ? DESC[239 - 8 * a -: 8] : 8'h00);
    end
    // Second flag pattern runs with the host stalling
    for (int p = 0; p < 2; p++) begin
      flags = p ? 4'b0110 : 4'b1001;
      slow = p[0];
      n0 = n_reports;
      repeat (130) @(negedge clock);
      chk("report count", {7'h0, (n_reports - n0) inside {3, 4}}, 8'h01);
      chk("reserved bytes", report[31:24] | report[23:16], 8'h00);
      chk("status byte", report[15:8], 8'ha8);
      chk("flag byte", report[7:0], p ? 8'h06 : 8'h09);
    end
    nrst = 1'b0;
    @(negedge clock);
    chk("data after reset", printer_data_pins_out, 8'h00);
    nrst = 1'b1;
    req(REQ_TYPE_READ, REQ_CODE_READ, 16'h0100, OFS_DATA, LEN_READ);
    chk("data read after reset", ctl_rd_data, 8'h00);
    finish_test();
  end
endmodule // upv_port_access_tb_top
`default_nettype wire
